// File: logic/acc_control.sv
// Converter control register, start selection, busy and completion flag, result justify
`timescale 1ns/100ps
`default_nettype none

module acc_control (
  // Clock and reset
  input  wire  logic                         clock,
  input  wire  logic                         rst,
  input  wire  logic                         clock_enable,
  // Special-function register port, bit writes arrive as byte writes
  input  wire  logic [7:0]                   sfr_addr,
  input  wire  logic                         sfr_write,
  input  wire  logic [7:0]                   sfr_wdata,
  output logic       [7:0]                   sfr_rdata,
  // Start sources
  input  wire  logic                         timer2_overflow,
  input  wire  logic                         timer3_overflow,
  input  wire  logic                         external_convert_start,
  // Converter core
  input  wire  logic                         core_done,
  input  wire  logic [acc_pkg::RESULT_W-1:0] core_result,
  input  wire  logic                         differential,
  input  wire  logic                         window_hit,
  output logic                               core_start,
  output logic                               core_shutdown,
  output logic                               core_track,
  // Result bytes
  output logic       [7:0]                   result_high_byte,
  output logic       [7:0]                   result_low_byte
);
  import acc_pkg::*;

  // Byte views of the result
  localparam int BYTE_W    = 8;
  localparam int HI_KEEP_W = RESULT_W - BYTE_W;
  localparam int LO_PAD_W  = (2 * BYTE_W) - RESULT_W;
  localparam int N_FLAGS   = 2;
  localparam int FLAG_POS [N_FLAGS] = '{BIT_DONE, BIT_WINDOW};

  // The result must spread over both data bytes, and padding must match sign width
  if ((RESULT_W <= BYTE_W) ||
      (RESULT_W > (2 * BYTE_W)) ||
      (SIGN_W != LO_PAD_W)) begin : g_bad_width
    $error("acc_control: result width does not fit the two data bytes");
  end

  typedef struct packed {
    logic [BYTE_W-1:0] ctrl;
    acc_state_t        state;
    logic              external_convert_start_d;
    logic [BYTE_W-1:0] res_hi;
    logic [BYTE_W-1:0] res_lo;
  } acc_regs_t;

  acc_regs_t          r;
  acc_regs_t          next_r;
  logic               ctrl_wr;
  logic               enabled;
  logic               stay_enabled;
  logic               track0;
  logic [1:0]         src;
  logic               sw_start;
  logic               hw_start;
  logic               start_req;
  logic               busy;
  logic               abort;
  logic               finish;
  logic [BYTE_W-1:0]  wr_ctrl;
  logic [N_FLAGS-1:0] kept_flag;
  logic               sign_bit;
  logic [BYTE_W-1:0]  fmt_hi;
  logic [BYTE_W-1:0]  fmt_lo;

  // Register decode
  assign ctrl_wr = sfr_write && (sfr_addr == ACC_CTRL_ADDR);
  assign enabled = r.ctrl[BIT_ENABLE];
  assign track0  = !r.ctrl[BIT_TRACK];
  assign src     = r.ctrl[BIT_SRC_HI:BIT_SRC_LO];
  assign busy    = (r.state == ACC_CONVERT);

  // A disabling write counts at once, so busy never reads 1 while off
  assign stay_enabled = ctrl_wr ? sfr_wdata[BIT_ENABLE] : enabled;

  // Source field in force before the write decides a software start
  assign sw_start = ctrl_wr && sfr_wdata[BIT_BUSY] && (src == SRC_SOFTWARE);

  // Track mode 1 delayed starts need the SAR clock, so Timer 2 starts are served in track mode 0 only; Timer 3 and external starts ignore the track bit
  always_comb begin
    case (src)
      SRC_TIMER3: begin
        hw_start = timer3_overflow;
      end
      SRC_EXTERNAL: begin
        hw_start = external_convert_start && !r.external_convert_start_d;
      end
      SRC_TIMER2: begin
        hw_start = timer2_overflow && track0;
      end
      default: begin
        hw_start = 1'b0;
      end
    endcase
  end

  // Starts while busy or off are dropped without trace
  assign start_req = enabled && stay_enabled && !busy && (sw_start || hw_start);

  // Conversion ends by abort or by the core's done pulse
  assign abort  = busy && !stay_enabled;
  assign finish = busy && stay_enabled && core_done;

  // Flags clear on a written 0 and keep on a written 1
  for (genvar g = 0; g < N_FLAGS; g++) begin : g_flag
    assign kept_flag[g] = r.ctrl[FLAG_POS[g]] & sfr_wdata[FLAG_POS[g]];
  end

  // Control byte as a write leaves it; busy is never stored
  always_comb begin
    wr_ctrl = sfr_wdata;
    wr_ctrl[BIT_BUSY] = 1'b0;
    for (int i = 0; i < N_FLAGS; i++) begin
      wr_ctrl[FLAG_POS[i]] = kept_flag[i];
    end
  end

  // Result formatting; the justify bit counts at the done edge
  assign sign_bit = differential & core_result[RESULT_W-1];
  always_comb begin
    if (r.ctrl[BIT_LJUST]) begin
      fmt_hi = core_result[RESULT_W-1:RESULT_W-BYTE_W];
      fmt_lo = {core_result[HI_KEEP_W-1:0], {LO_PAD_W{1'b0}}};
    end else begin
      fmt_hi = {{SIGN_W{sign_bit}}, core_result[RESULT_W-1:BYTE_W]};
      fmt_lo = core_result[BYTE_W-1:0];
    end
  end

  // Next state; a hardware flag set lands after the write so the set wins
  always_comb begin
    next_r          = r;
    next_r.external_convert_start_d = external_convert_start;
    if (ctrl_wr) begin
      next_r.ctrl = wr_ctrl;
    end
    case (r.state)
      ACC_IDLE: begin
        if (start_req) begin
          next_r.state = ACC_CONVERT;
        end
      end
      ACC_CONVERT: begin
        if (abort) begin
          next_r.state = ACC_IDLE;
        end else if (finish) begin
          next_r.state = ACC_IDLE;
          next_r.ctrl[BIT_DONE] = 1'b1;
          if (window_hit) begin
            next_r.ctrl[BIT_WINDOW] = 1'b1;
          end
          next_r.res_hi = fmt_hi;
          next_r.res_lo = fmt_lo;
        end
      end
      default: begin
        next_r.state = ACC_IDLE;
      end
    endcase
  end

  // State register; clock enable low freezes everything
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      r <= '{ctrl: ACC_CTRL_RESET, state: ACC_IDLE, external_convert_start_d: 1'b0,
             res_hi: '0, res_lo: '0};
    end else if (clock_enable) begin
      r <= next_r;
    end
  end

  // Status read; busy is the live state, not a stored bit
  always_comb begin
    sfr_rdata = r.ctrl;
    sfr_rdata[BIT_BUSY] = busy;
  end

  // Core side
  assign core_start    = start_req && clock_enable;
  assign core_shutdown = !enabled;
  assign core_track    = enabled && !busy && track0;

  // Result bytes
  assign result_high_byte = r.res_hi;
  assign result_low_byte  = r.res_lo;
endmodule // acc_control

`default_nettype wire

// File: logic/acc_pkg.sv
// Package of register map, field positions and states for the converter control block
package acc_pkg;
  localparam logic [7:0] ACC_CTRL_ADDR  = 8'hE8;
  localparam logic [7:0] ACC_CTRL_RESET = 8'h00;
  localparam int BIT_ENABLE  = 7;
  localparam int BIT_TRACK   = 6;
  localparam int BIT_DONE    = 5;
  localparam int BIT_BUSY    = 4;
  localparam int BIT_SRC_HI  = 3;
  localparam int BIT_SRC_LO  = 2;
  localparam int BIT_WINDOW  = 1;
  localparam int BIT_LJUST   = 0;
  localparam logic [1:0] SRC_SOFTWARE = 2'h0;
  localparam logic [1:0] SRC_TIMER3   = 2'h1;
  localparam logic [1:0] SRC_EXTERNAL = 2'h2;
  localparam logic [1:0] SRC_TIMER2   = 2'h3;
  localparam int RESULT_W = 10;
  localparam int SIGN_W   = 6;

  typedef enum logic [1:0] {
    ACC_IDLE    = 2'h0,
    ACC_CONVERT = 2'h1
  } acc_state_t;
endpackage

// File: tb/acc_control_monitor.sv
// Checker for the converter control block
`timescale 1ns/100ps
`default_nettype none
module acc_control_monitor (
  input wire logic clock, rst, clock_enable, sfr_write, timer2_overflow, core_done,
  input wire logic differential, core_start, core_shutdown, core_track,
  input wire logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, result_high_byte, result_low_byte,
  input wire logic [9:0] core_result
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst || !clock_enable);
  wire logic [7:0] r = sfr_rdata;
  wire logic [15:0] res = {result_high_byte, result_low_byte};
  a_track_idle: assert property (core_track == (r[7] && !r[6] && !r[4])) else $error("track");
  a_busy_start: assert property (core_start |=> r[4]) else $error("busy");
  a_done_flag: assert property ($fell(r[4]) && r[7] |-> r[5]) else $error("flag");
  a_sw_start: assert property (sfr_write && sfr_addr == 8'hE8 && sfr_wdata[7] && r[7]
    && sfr_wdata[4] && r[3:2] == 2'h0 && !r[4] |-> core_start) else $error("sw");
  a_timer_go: assert property (timer2_overflow && r[7:6] == 2'h2 && r[3:2] == 2'h3 && !r[4]
    && !sfr_write |-> core_start) else $error("timer");
  a_off_idle: assert property (!r[7] |-> core_shutdown && !r[4] && !core_start)
    else $error("off");
  a_right_just: assert property (core_done && r[4] && r[7] && !r[0] && !differential |=>
    res == {6'h00, $past(core_result)}) else $error("right");
  a_left_just: assert property (core_done && r[4] && r[7] && r[0] |=>
    res == {$past(core_result), 6'h00}) else $error("left");
  cover property (core_start);
  cover property ($fell(r[4]));
  cover property (core_done && r[0]);
endmodule // acc_control_monitor
bind acc_control acc_control_monitor u_acc_control_monitor (.*);
`default_nettype wire

// File: tb/acc_control_tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/100ps
`default_nettype none
module acc_control_tb;
  logic clock = 1'b0, rst = 1'b1, wr_en = 1'b0, t2 = 1'b0, diff = 1'b0, ce = 1'b1, done, start;
  logic [7:0] wd = 8'h00, rd, hi, lo;
  logic [9:0] res;
  int n_fail = 0, checked = 0;
  acc_control u_acc_control (.clock, .rst, .clock_enable(ce), .sfr_addr(8'hE8),
    .sfr_write(wr_en), .sfr_wdata(wd), .sfr_rdata(rd), .timer2_overflow(t2),
    .timer3_overflow(1'b0), .external_convert_start(1'b0), .core_done(done), .core_result(res),
    .differential(diff), .window_hit(1'b0), .core_start(start), .core_shutdown(),
    .core_track(), .result_high_byte(hi), .result_low_byte(lo));
  acc_core_model u_acc_core_model (.clock, .core_start(start), .sample(10'h2A5),
    .core_done(done), .core_result(res));
  task automatic chk(input logic [15:0] got, exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] d);
    @(posedge clock) #1 wr_en = 1'b1;
    wd = d;
    @(posedge clock) #1 wr_en = 1'b0;
  endtask
  // Bounded wait for busy to drop, then flags and result bytes
  task automatic fin(input logic [15:0] exp);
    for (int i = 0; i < 20 && rd[4] !== 1'b0; i++) @(posedge clock) #1;
    chk({8'h00, rd & 8'hF0}, 16'h00A0);
    chk({hi, lo}, exp);
  endtask
  task t_reset; chk({8'h00, rd}, 16'h0000); endtask
  task t_soft; wr(8'h80); wr(8'h90); chk({15'h0000, rd[4]}, 16'h0001); fin(16'h02A5); endtask
  task t_sign; diff = 1'b1; wr(8'h90); fin(16'hFEA5); diff = 1'b0; endtask
  task t_left; wr(8'h91); fin(16'hA940); endtask
  task t_timer; wr(8'h8C); chk({8'h00, rd}, 16'h008C); t2 = 1'b1;
    @(posedge clock) #1 t2 = 1'b0; fin(16'h02A5); endtask
  task t_freeze; ce = 1'b0; wr(8'h00); chk({8'h00, rd}, 16'h00AC); ce = 1'b1; endtask
  task t_off; wr(8'h10); chk({8'h00, rd}, 16'h0000);
    wr(8'h10); chk({8'h00, rd}, 16'h0000); endtask
  task automatic tally_and_finish;
    $display("checked %0d failed %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial forever #5 clock = ~clock;
  initial begin
    repeat (2) @(posedge clock);
    #1 rst = 1'b0;
    t_reset; t_soft; t_sign; t_left; t_timer; t_freeze; t_off;
    tally_and_finish;
  end
  initial begin
    #20000 n_fail++;
    tally_and_finish;
  end
endmodule // acc_control_tb
`default_nettype wire

// File: tb/acc_core_model.sv
// Converter core model: fixed latency, result held only in the done cycle
`timescale 1ns/100ps
`default_nettype none
module acc_core_model #(parameter int LAT = 5) (
  input wire logic clock, core_start,
  input wire logic [9:0] sample,
  output logic core_done,
  output logic [9:0] core_result
);
  int n = 0;
  logic [9:0] v = 10'h000;
  initial core_done = 1'b0;
  always @(posedge clock) begin
    core_done <= (n == 1);
    if (core_start) begin
      n <= LAT;
      v <= sample;
    end else if (n > 0) n <= n - 1;
  end
  // Stale value inverted so a late sample is caught
  assign core_result = core_done ? v : ~v;
endmodule // acc_core_model
`default_nettype wire
